// ===== fsq_pkg.sv
package fsq_pkg;

  // ************************************************************
  // Register byte offsets on the bus
  // ************************************************************
  localparam logic [7:0] FSQ_OFF_DIV   = 8'h00;
  localparam logic [7:0] FSQ_OFF_OPT   = 8'h04;
  localparam logic [7:0] FSQ_OFF_PROT  = 8'h08;
  localparam logic [7:0] FSQ_OFF_STAT  = 8'h0C;
  localparam logic [7:0] FSQ_OFF_CMD   = 8'h10;
  localparam logic [7:0] FSQ_OFF_ARRAY = 8'h14;
  localparam logic [7:0] FSQ_OFF_KEYLO = 8'h18;
  localparam logic [7:0] FSQ_OFF_KEYHI = 8'h1C;
  localparam logic [7:0] FSQ_OFF_CAL   = 8'h20;

  // ************************************************************
  // Nonvolatile location indices
  // ************************************************************
  localparam logic [15:0] FSQ_NV_CAL_LOW_IDX  = 16'hFFAD;
  localparam logic [15:0] FSQ_NV_CAL_HIGH_IDX = 16'hFFAE;
  localparam logic [15:0] FSQ_NV_COARSE_IDX   = 16'hFFAF;
  localparam logic [15:0] FSQ_NV_KEY_IDX      = 16'hFFB0;
  localparam logic [15:0] FSQ_NV_PROT_IDX     = 16'hFFBD;
  localparam logic [15:0] FSQ_NV_OPT_IDX      = 16'hFFBF;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int FSQ_DIV_LOADED_BIT = 7;
  localparam int FSQ_DIV_PRE8_BIT   = 6;
  localparam int FSQ_DIV_W          = 6;
  localparam int FSQ_OPT_KEY_BIT    = 7;
  localparam int FSQ_OPT_NORED_BIT  = 6;
  localparam int FSQ_ST_BEF_BIT     = 7;
  localparam int FSQ_ST_CCF_BIT     = 6;
  localparam int FSQ_ST_ERR_BIT     = 4;
  localparam int FSQ_ST_BLANK_BIT   = 2;
  localparam int FSQ_FINE_BIT       = 0;
  localparam int FSQ_ARR_DATA_LSB   = 16;
  localparam int FSQ_PAGE_LSB       = 9;
  localparam int FSQ_ROW_W          = 6;

  // ************************************************************
  // Codes and values
  // ************************************************************
  localparam logic [1:0] FSQ_SEC_OPEN       = 2'h2;
  localparam logic [7:0] FSQ_CMD_BLANK      = 8'h05;
  localparam logic [7:0] FSQ_CMD_BYTE       = 8'h20;
  localparam logic [7:0] FSQ_CMD_BURST      = 8'h25;
  localparam logic [7:0] FSQ_CMD_PAGE_ERASE = 8'h40;
  localparam logic [7:0] FSQ_CMD_MASS_ERASE = 8'h41;
  localparam logic [7:0] FSQ_NV_RESET_VAL   = 8'hFF;

  // ************************************************************
  // Pulse lengths in flash clock periods
  // ************************************************************
  localparam int FSQ_CYC_W          = 15;
  localparam int FSQ_BYTE_CYC       = 9;
  localparam int FSQ_BURST_CYC      = 4;
  localparam int FSQ_PAGE_ERASE_CYC = 4000;
  localparam int FSQ_MASS_ERASE_CYC = 20000;

  typedef enum logic [1:0] {
    FSQ_OP_PROGRAM,
    FSQ_OP_PAGE_ERASE,
    FSQ_OP_MASS_ERASE,
    FSQ_OP_BLANK
  } fsq_op_t;

  typedef enum {
    FSQ_IDLE,
    FSQ_HAVE_ADDR,
    FSQ_HAVE_CMD,
    FSQ_RUN
  } fsq_state_t;

endpackage

// ===== fsq_pulse_timer.sv
`timescale 1ns/1ps
module fsq_pulse_timer
  import fsq_pkg::*;
#(
  parameter int DW = FSQ_DIV_W,
  parameter int CW = FSQ_CYC_W
) (
  input  wire logic          i_clk,
  input  wire logic          i_reset_n,
  input  wire logic          i_ce,
  input  wire logic [DW-1:0] i_div,
  input  wire logic          i_prediv8,
  input  wire logic          i_start,
  input  wire logic [CW-1:0] i_cycles,
  output logic               o_busy,
  output logic               o_done
);

  logic [2:0]    pre_q;
  logic [DW-1:0] div_q;
  logic [CW-1:0] left_q;
  logic          busy_q;
  logic          done_q;
  wire           pre_wrap = !i_prediv8 || (pre_q == 3'h7);
  wire           tick     = pre_wrap && (div_q == i_div);
  wire           last     = tick && (left_q == CW'(1));

  // ************************************************************
  // Flash clock from bus clock, counted pulse
  // ************************************************************
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pre_q  <= 3'h0;
      div_q  <= '0;
      left_q <= '0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else if (i_ce) begin
      done_q <= last && busy_q;
      if (i_start && !busy_q) begin
        pre_q  <= 3'h0;
        div_q  <= '0;
        left_q <= i_cycles;
        busy_q <= 1'b1;
      end else if (busy_q) begin
        pre_q <= i_prediv8 ? pre_q + 3'h1 : 3'h0;
        if (pre_wrap) begin
          div_q <= tick ? '0 : div_q + DW'(1);
        end
        if (tick) begin
          left_q <= left_q - CW'(1);
          busy_q <= !last;
        end
      end
    end
  end

  assign o_busy = busy_q;
  assign o_done = done_q;

endmodule

// ===== fsq_sequencer.sv
`timescale 1ns/1ps
module fsq_sequencer
  import fsq_pkg::*;
#(
  parameter int P_BYTE_CYC       = FSQ_BYTE_CYC,
  parameter int P_BURST_CYC      = FSQ_BURST_CYC,
  parameter int P_PAGE_ERASE_CYC = FSQ_PAGE_ERASE_CYC,
  parameter int P_MASS_ERASE_CYC = FSQ_MASS_ERASE_CYC
) (
  input  wire logic        i_clk,
  input  wire logic        i_reset_n,
  input  wire logic        i_ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        i_debug_access,
  input  wire logic        i_secure_code,
  input  wire logic [7:0]  i_stored_protection_byte,
  input  wire logic [7:0]  i_stored_option_byte,
  input  wire logic [63:0] i_backdoor_compare_key,
  input  wire logic [7:0]  i_adc_cal_low_byte,
  input  wire logic [7:0]  i_adc_cal_high_fine_adjust,
  input  wire logic [7:0]  i_clock_coarse_adjust_store,
  input  wire logic        i_array_blank,
  output logic             o_secure,
  output logic             o_array_active,
  output logic      [1:0]  o_array_op,
  output logic      [15:0] o_array_addr,
  output logic      [7:0]  o_array_data,
  output logic      [6:0]  o_protect_boundary_field,
  output logic             o_protect_disable_bit,
  output logic             o_vector_redirect_disable,
  output logic             o_fine_clock_adjust_bit,
  output logic      [7:0]  o_coarse_clock_adjust
);

  // ************************************************************
  // Decode helpers
  // ************************************************************
  function automatic logic cmd_valid(input logic [7:0] c);
    return (c == FSQ_CMD_BLANK) || (c == FSQ_CMD_BYTE) || (c == FSQ_CMD_BURST)
        || (c == FSQ_CMD_PAGE_ERASE) || (c == FSQ_CMD_MASS_ERASE);
  endfunction

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction

  // ************************************************************
  // State
  // ************************************************************
  fsq_state_t    state_q, state_d;
  logic [7:0]    div_q;
  logic [7:0]    working_option_reg_q;
  logic [7:0]    working_protection_reg_q;
  logic          nv_loaded_q;
  logic          access_error_flag_q;
  logic          blank_q;
  logic          secure_q;
  logic          mass_erased_q;
  logic [7:0]    cmd_q;
  logic [15:0]   addr_q;
  logic [7:0]    data_q;
  logic [15:0]   last_addr_q;
  logic          last_burst_q;
  logic [31:0]   key_lo_q;
  logic [31:0]   rdata_q;
  logic          ready_q;
  logic          slverr_q;
  logic [14:0]   pulse_cycles;
  logic          timer_busy;
  logic          timer_done;
  logic          launch;
  logic          set_err;

  // ************************************************************
  // Bus decode
  // ************************************************************
  wire access   = psel && penable;
  wire wr       = access && pwrite && ready_q && i_ce;
  wire mapped   = hit(paddr, FSQ_OFF_DIV) || hit(paddr, FSQ_OFF_OPT)
               || hit(paddr, FSQ_OFF_PROT) || hit(paddr, FSQ_OFF_STAT)
               || hit(paddr, FSQ_OFF_CMD) || hit(paddr, FSQ_OFF_ARRAY)
               || hit(paddr, FSQ_OFF_KEYLO) || hit(paddr, FSQ_OFF_KEYHI)
               || hit(paddr, FSQ_OFF_CAL);
  wire wr_div   = wr && hit(paddr, FSQ_OFF_DIV);
  wire wr_prot  = wr && (hit(paddr, FSQ_OFF_PROT) || hit(paddr, FSQ_OFF_OPT));
  wire wr_stat  = wr && hit(paddr, FSQ_OFF_STAT);
  wire wr_cmd   = wr && hit(paddr, FSQ_OFF_CMD);
  wire wr_array = wr && hit(paddr, FSQ_OFF_ARRAY);
  wire wr_keylo = wr && hit(paddr, FSQ_OFF_KEYLO);
  wire wr_keyhi = wr && hit(paddr, FSQ_OFF_KEYHI);

  wire key_unlock_allow     = working_option_reg_q[FSQ_OPT_KEY_BIT];
  wire [1:0] security_state_field = i_stored_option_byte[1:0];
  wire div_loaded           = div_q[FSQ_DIV_LOADED_BIT];
  wire buffer_empty_flag    = (state_q == FSQ_IDLE);
  wire command_complete_flag = buffer_empty_flag;
  wire [7:0] flash_status_reg = {buffer_empty_flag, command_complete_flag, 1'b0,
                                 access_error_flag_q, 1'b0, blank_q, 2'b00};
  wire stat_launch = wr_stat && pwdata[FSQ_ST_BEF_BIT];
  wire stat_abort  = wr_stat && !pwdata[FSQ_ST_BEF_BIT];
  wire clear_err   = wr_stat && pwdata[FSQ_ST_ERR_BIT];
  wire debug_limited = i_debug_access && secure_q
                    && ((pwdata[7:0] == FSQ_CMD_BYTE) || (pwdata[7:0] == FSQ_CMD_BURST)
                    || (pwdata[7:0] == FSQ_CMD_PAGE_ERASE));
  wire burst_follow = (cmd_q == FSQ_CMD_BURST) && last_burst_q
                   && (addr_q == last_addr_q + 16'h0001)
                   && (addr_q[FSQ_ROW_W-1:0] != '0);
  wire key_trial    = wr_keyhi && key_unlock_allow && i_secure_code
                   && !i_debug_access;
  wire key_match    = {pwdata, key_lo_q} == i_backdoor_compare_key;

  // ************************************************************
  // Command sequence
  // ************************************************************
  always_comb begin
    state_d = state_q;
    launch  = 1'b0;
    set_err = 1'b0;
    case (state_q)
      FSQ_IDLE: begin
        if (wr_array) begin
          if (access_error_flag_q || !div_loaded) begin
            set_err = !access_error_flag_q;
          end else begin
            state_d = FSQ_HAVE_ADDR;
          end
        end else if (wr_cmd) begin
          set_err = 1'b1;
        end
      end
      FSQ_HAVE_ADDR: begin
        if (wr_cmd) begin
          if (!cmd_valid(pwdata[7:0]) || debug_limited) begin
            set_err = 1'b1;
            state_d = FSQ_IDLE;
          end else begin
            state_d = FSQ_HAVE_CMD;
          end
        end else if (stat_abort || stat_launch || wr_array || wr_div || wr_prot) begin
          set_err = 1'b1;
          state_d = FSQ_IDLE;
        end
      end
      FSQ_HAVE_CMD: begin
        if (stat_launch) begin
          launch  = 1'b1;
          state_d = FSQ_RUN;
        end else if (stat_abort || wr_cmd || wr_array || wr_div || wr_prot) begin
          set_err = 1'b1;
          state_d = FSQ_IDLE;
        end
      end
      FSQ_RUN: begin
        if (wr_array) begin
          set_err = 1'b1;
        end
        if (timer_done) begin
          state_d = FSQ_IDLE;
        end
      end
      default: begin
        state_d = FSQ_IDLE;
      end
    endcase
  end

  // ************************************************************
  // Pulse length selection
  // ************************************************************
  always_comb begin
    case (cmd_q)
      FSQ_CMD_BYTE:       pulse_cycles = 15'(P_BYTE_CYC);
      FSQ_CMD_BURST:      pulse_cycles = burst_follow ? 15'(P_BURST_CYC)
                                                      : 15'(P_BYTE_CYC);
      FSQ_CMD_PAGE_ERASE: pulse_cycles = 15'(P_PAGE_ERASE_CYC);
      FSQ_CMD_MASS_ERASE: pulse_cycles = 15'(P_MASS_ERASE_CYC);
      default:            pulse_cycles = 15'(P_BYTE_CYC);
    endcase
  end

  fsq_pulse_timer #(
    .DW (FSQ_DIV_W),
    .CW (FSQ_CYC_W)
  ) u_timer (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .i_ce      (i_ce),
    .i_div     (div_q[FSQ_DIV_W-1:0]),
    .i_prediv8 (div_q[FSQ_DIV_PRE8_BIT]),
    .i_start   (launch),
    .i_cycles  (pulse_cycles),
    .o_busy    (timer_busy),
    .o_done    (timer_done)
  );

  // ************************************************************
  // Sequence registers
  // ************************************************************
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_q             <= FSQ_IDLE;
      access_error_flag_q <= 1'b0;
      cmd_q               <= 8'h00;
      addr_q              <= 16'h0000;
      data_q              <= 8'h00;
    end else if (i_ce) begin
      state_q <= state_d;
      if (set_err) begin
        access_error_flag_q <= 1'b1;
      end else if (clear_err) begin
        access_error_flag_q <= 1'b0;
      end
      if (wr_array && state_d == FSQ_HAVE_ADDR && state_q == FSQ_IDLE) begin
        addr_q <= pwdata[15:0];
        data_q <= pwdata[FSQ_ARR_DATA_LSB +: 8];
      end
      if (wr_cmd && state_d == FSQ_HAVE_CMD) begin
        cmd_q <= pwdata[7:0];
      end
    end
  end

  // ************************************************************
  // Divider, blank result, burst history
  // ************************************************************
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      div_q         <= 8'h00;
      blank_q       <= 1'b0;
      mass_erased_q <= 1'b0;
      last_addr_q   <= 16'h0000;
      last_burst_q  <= 1'b0;
    end else if (i_ce) begin
      if (wr_div && !div_loaded && !access_error_flag_q && state_q == FSQ_IDLE) begin
        div_q <= {1'b1, pwdata[FSQ_DIV_PRE8_BIT:0]};
      end
      if (launch) begin
        blank_q      <= 1'b0;
        last_addr_q  <= addr_q;
        last_burst_q <= (cmd_q == FSQ_CMD_BURST);
      end
      if (timer_done) begin
        if (cmd_q == FSQ_CMD_BLANK) begin
          blank_q <= i_array_blank;
        end
        if (cmd_q == FSQ_CMD_MASS_ERASE) begin
          mass_erased_q <= 1'b1;
        end else if (cmd_q != FSQ_CMD_BLANK) begin
          mass_erased_q <= 1'b0;
        end
      end
    end
  end

  // ************************************************************
  // Stored byte load and security
  // ************************************************************
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      nv_loaded_q              <= 1'b0;
      working_option_reg_q     <= FSQ_NV_RESET_VAL;
      working_protection_reg_q <= FSQ_NV_RESET_VAL;
      secure_q                 <= 1'b1;
      key_lo_q                 <= 32'h0000_0000;
    end else if (i_ce) begin
      if (!nv_loaded_q) begin
        nv_loaded_q              <= 1'b1;
        working_option_reg_q     <= i_stored_option_byte;
        working_protection_reg_q <= i_stored_protection_byte;
        secure_q <= security_state_field != FSQ_SEC_OPEN;
      end else begin
        if (key_trial && key_match) begin
          secure_q <= 1'b0;
        end
        if (timer_done && cmd_q == FSQ_CMD_BLANK && i_array_blank && mass_erased_q) begin
          secure_q <= 1'b0;
        end
      end
      if (wr_keylo && i_secure_code && !i_debug_access) begin
        key_lo_q <= pwdata;
      end
    end
  end

  // ************************************************************
  // Bus read path, one wait state
  // ************************************************************
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ready_q  <= 1'b0;
      slverr_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
    end else if (i_ce) begin
      ready_q  <= access && !ready_q;
      slverr_q <= access && !ready_q && !mapped;
      if (access && !ready_q) begin
        case (paddr)
          FSQ_OFF_DIV:  rdata_q <= {24'h000000, div_q};
          FSQ_OFF_OPT:  rdata_q <= {24'h000000, working_option_reg_q};
          FSQ_OFF_PROT: rdata_q <= {24'h000000, working_protection_reg_q};
          FSQ_OFF_STAT: rdata_q <= {24'h000000, flash_status_reg};
          FSQ_OFF_CMD:  rdata_q <= {24'h000000, cmd_q};
          FSQ_OFF_CAL:  rdata_q <= {8'h00, i_adc_cal_low_byte, i_adc_cal_high_fine_adjust,
                                    i_clock_coarse_adjust_store};
          default:      rdata_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign prdata  = rdata_q;
  assign pready  = ready_q;
  assign pslverr = slverr_q;
  assign o_secure       = secure_q;
  assign o_array_active = timer_busy;
  assign o_array_op     = (cmd_q == FSQ_CMD_PAGE_ERASE) ? 2'(FSQ_OP_PAGE_ERASE)
                        : (cmd_q == FSQ_CMD_MASS_ERASE) ? 2'(FSQ_OP_MASS_ERASE)
                        : (cmd_q == FSQ_CMD_BLANK)      ? 2'(FSQ_OP_BLANK)
                        : 2'(FSQ_OP_PROGRAM);
  assign o_array_addr   = (cmd_q == FSQ_CMD_PAGE_ERASE)
                        ? {addr_q[15:FSQ_PAGE_LSB], 9'h000} : addr_q;
  assign o_array_data   = data_q;
  assign o_protect_boundary_field  = working_protection_reg_q[7:1];
  assign o_protect_disable_bit     = working_protection_reg_q[0];
  assign o_vector_redirect_disable = working_option_reg_q[FSQ_OPT_NORED_BIT];
  assign o_fine_clock_adjust_bit   = i_adc_cal_high_fine_adjust[FSQ_FINE_BIT];
  assign o_coarse_clock_adjust     = i_clock_coarse_adjust_store;

endmodule

// ===== fsq_sequencer_sva.sv
`timescale 1ns/1ps
module fsq_sequencer_sva
  import fsq_pkg::*;
(
  input wire logic        i_clk,
  input wire logic        i_reset_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        i_debug_access,
  input wire logic [7:0]  i_stored_protection_byte,
  input wire logic [7:0]  i_stored_option_byte,
  input wire logic        o_secure,
  input wire logic        o_array_active,
  input wire logic [1:0]  o_array_op,
  input wire logic [15:0] o_array_addr,
  input wire logic        o_protect_disable_bit,
  input wire logic        o_vector_redirect_disable
);
  // ********************
  // Bus decode helpers
  // ********************
  wire logic wr_done = psel && penable && pready && pwrite;
  wire logic go_wr   = wr_done && paddr == FSQ_OFF_STAT && pwdata[FSQ_ST_BEF_BIT];
  wire logic key_wr  = wr_done && paddr == FSQ_OFF_KEYHI;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);

  property p_answer;
    psel && penable && !pready |=> pready ##1 !pready;
  endproperty
  a_answer: assert property (p_answer) else $error("bus answer not after one wait");
  property p_slverr;
    pslverr |-> pready;
  endproperty
  a_slverr: assert property (p_slverr) else $error("error response without ready");
  property p_secure;
    $rose(i_reset_n) |=> o_secure == (i_stored_option_byte[1:0] != FSQ_SEC_OPEN);
  endproperty
  a_secure: assert property (p_secure) else $error("security state wrong after reset");
  property p_load;
    $rose(i_reset_n) |=> o_vector_redirect_disable == i_stored_option_byte[FSQ_OPT_NORED_BIT]
      && o_protect_disable_bit == i_stored_protection_byte[0];
  endproperty
  a_load: assert property (p_load) else $error("working bytes not loaded at reset");
  property p_page;
    $rose(o_array_active) && o_array_op == FSQ_OP_PAGE_ERASE |-> o_array_addr[8:0] == 9'h000;
  endproperty
  a_page: assert property (p_page) else $error("page erase address not page aligned");
  property p_launch;
    $rose(o_array_active) |-> $past(go_wr) || $past(go_wr, 2);
  endproperty
  a_launch: assert property (p_launch) else $error("array started without launch");
  property p_key;
    key_wr && (i_debug_access || !i_stored_option_byte[FSQ_OPT_KEY_BIT]) |=> $stable(o_secure);
  endproperty
  a_key: assert property (p_key) else $error("key accepted when not allowed");
  property p_hold;
    o_array_active ##1 o_array_active |-> $stable(o_array_addr);
  endproperty
  a_hold: assert property (p_hold) else $error("latched address moved while running");
endmodule

// ===== fsq_apb_master.sv
`timescale 1ns/1ps
module fsq_apb_master (
  input  wire logic        i_clk,
  input  wire logic        pready,
  input  wire logic [31:0] prdata,
  output logic             psel    = 1'b0,
  output logic             penable = 1'b0,
  output logic             pwrite  = 1'b0,
  output logic      [7:0]  paddr   = 8'h00,
  output logic      [31:0] pwdata  = 32'h0
);
  // ********************
  // One transfer, optional idle gap first
  // ********************
  task automatic xfer(input int gap, input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] rd);
    repeat (gap) @(posedge i_clk);
    @(posedge i_clk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge i_clk);
    penable <= 1'b1;
    do @(posedge i_clk); while (pready !== 1'b1);
    rd = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
    // Released data is inverted
    pwdata  <= ~d;
  endtask
endmodule

// ===== tb_flash_command_sequencer.sv
`timescale 1ns/1ps
module tb_flash_command_sequencer;
  import fsq_pkg::*;
  localparam int PG_CYC = 20;
  localparam int MS_CYC = 40;
  localparam int PULSE_TIMING_CLOCK   = 256;
  logic        i_clk     = 1'b0;
  logic        i_reset_n = 1'b0;
  logic        psel, penable, pwrite, pready, pslverr, secure, active, fine;
  logic [7:0]  paddr, data, coarse, d;
  logic [31:0] pwdata, prdata;
  logic        dbg  = 1'b0;
  logic        sc   = 1'b1;
  logic        blank = 1'b1;
  logic [7:0]  prot = 8'hFF;
  logic [7:0]  opt  = 8'hFF;
  logic [63:0] key  = 64'h0;
  logic [23:0] cal  = 24'h0;
  logic [1:0]  op;
  logic [6:0]  pbf;
  logic [15:0] addr, a;
  logic [71:0] exp_q[$];
  logic [71:0] e;
  int          bad_count = 0;
  int          checks    = 0;
  int          cycles    = 0;

  always #10 i_clk = ~i_clk;

  fsq_sequencer #(.P_PAGE_ERASE_CYC(PG_CYC), .P_MASS_ERASE_CYC(MS_CYC)) DUT (
    .i_clk(i_clk), .i_reset_n(i_reset_n), .i_ce(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .i_debug_access(dbg), .i_secure_code(sc),
    .i_stored_protection_byte(prot), .i_stored_option_byte(opt), .i_backdoor_compare_key(key),
    .i_adc_cal_low_byte(cal[23:16]), .i_adc_cal_high_fine_adjust(cal[15:8]),
    .i_clock_coarse_adjust_store(cal[7:0]), .i_array_blank(blank), .o_secure(secure),
    .o_array_active(active), .o_array_op(op), .o_array_addr(addr), .o_array_data(data),
    .o_protect_boundary_field(pbf), .o_protect_disable_bit(), .o_vector_redirect_disable(),
    .o_fine_clock_adjust_bit(fine), .o_coarse_clock_adjust(coarse));

  fsq_apb_master u_master (.i_clk(i_clk), .pready(pready), .prdata(prdata), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));

  // ********************
  // Checking and bus tasks
  // ********************
  task automatic check(input string n, input logic [31:0] ex, input logic [31:0] s);
    checks++;
    if (s !== ex) begin
      bad_count++;
      $display("Error %s expected %h seen %h", n, ex, s);
    end
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 60000) begin
      bad_count++;
      final_report();
    end
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      e = exp_q.pop_front();
      check($sformatf("reg %h", e[71:64]), e[31:0], prdata & e[63:32]);
      check("slverr", {31'h0, e[71:64] > FSQ_OFF_CAL}, {31'h0, pslverr});
    end
  end

  task automatic wr(input logic [7:0] ad, input logic [31:0] v);
    logic [31:0] r;
    u_master.xfer($urandom_range(0, 2), 1'b1, ad, v, r);
  endtask

  task automatic rd(input logic [7:0] ad, input logic [31:0] ex, input logic [31:0] m);
    logic [31:0] r;
    exp_q.push_back({ad, m, ex & m});
    u_master.xfer(0, 1'b0, ad, 32'h0, r);
  endtask

  task automatic cmd(input logic [15:0] ad, input logic [7:0] v, input logic [7:0] c);
    wr(FSQ_OFF_ARRAY, {8'h00, v, ad});
    wr(FSQ_OFF_CMD, {24'h0, c});
    wr(FSQ_OFF_STAT, 32'h80);
  endtask

  task automatic key_entry(input logic [63:0] k, input logic s);
    wr(FSQ_OFF_KEYLO, k[31:0]);
    wr(FSQ_OFF_KEYHI, k[63:32]);
    repeat (2) @(negedge i_clk);
    check("secure", {31'h0, s}, {31'h0, secure});
  endtask

  task automatic run(input int cyc, input logic [1:0] o, input logic [15:0] ad,
                     input logic [7:0] v);
    int n;
    n = 0;
    repeat (4) if (active !== 1'b1) @(negedge i_clk);
    check("array op", {30'h0, o}, {30'h0, op});
    check("array addr", {16'h0, ad}, {16'h0, addr});
    if (o == FSQ_OP_PROGRAM) check("array data", {24'h0, v}, {24'h0, data});
    while (active === 1'b1) begin
      @(negedge i_clk);
      n++;
    end
    if (cyc > 0) begin
      check("pulse length", 32'h1,
            {31'h0, n > (cyc - 1) * PULSE_TIMING_CLOCK && n < (cyc + 1) * PULSE_TIMING_CLOCK});
    end
  endtask

  task automatic do_reset(input logic [7:0] o);
    @(posedge i_clk) i_reset_n <= 1'b0;
    opt       <= o;
    repeat (12) @(posedge i_clk);
    check("secure in reset", 32'h1, {31'h0, secure});
    i_reset_n <= 1'b1;
    repeat (2) @(posedge i_clk);
  endtask

  // ********************
  // Main sequence
  // ********************
  initial begin
    void'($urandom(32'h1325));
    key  <= {$urandom, $urandom};
    cal  <= 24'($urandom);
    prot <= 8'($urandom);
    a = {10'($urandom), 6'h20};
    d = 8'($urandom);
    do_reset(8'h80);
    check("coarse adjust", {23'h0, cal[8], cal[7:0]}, {23'h0, fine, coarse});
    check("boundary", {25'h0, prot[7:1]}, {25'h0, pbf});
    rd(FSQ_OFF_OPT, 32'h80, 32'hFF);
    rd(FSQ_OFF_PROT, {24'h0, prot}, 32'hFF);
    rd(FSQ_OFF_CAL, {8'h0, cal}, 32'hFFFFFFFF);
    rd(FSQ_OFF_STAT, 32'hC0, 32'hFF);
    rd(8'h40, 32'h0, 32'hFFFFFFFF);
    wr(FSQ_OFF_ARRAY, 32'h0);
    rd(FSQ_OFF_STAT, 32'h10, 32'h10);
    wr(FSQ_OFF_DIV, 32'h41);
    wr(FSQ_OFF_STAT, 32'h10);
    wr(FSQ_OFF_DIV, 32'h5F);
    wr(FSQ_OFF_DIV, 32'h42);
    rd(FSQ_OFF_DIV, 32'hDF, 32'hFF);
    dbg <= 1'b1;
    key_entry(key, 1'b1);
    @(posedge i_clk) dbg <= 1'b0;
    sc <= 1'b0;
    key_entry(key, 1'b1);
    @(posedge i_clk) sc <= 1'b1;
    key_entry(~key, 1'b1);
    key_entry(key, 1'b0);
    cmd(a, d, FSQ_CMD_BYTE);
    run(FSQ_BYTE_CYC, FSQ_OP_PROGRAM, a, d);
    rd(FSQ_OFF_STAT, 32'hC0, 32'hFF);
    a = {a[15:6], 6'h10};
    cmd(a, d, FSQ_CMD_BURST);
    run(FSQ_BYTE_CYC, FSQ_OP_PROGRAM, a, d);
    cmd(a + 16'h1, ~d, FSQ_CMD_BURST);
    run(FSQ_BURST_CYC, FSQ_OP_PROGRAM, a + 16'h1, ~d);
    cmd(a, d, FSQ_CMD_PAGE_ERASE);
    wr(FSQ_OFF_ARRAY, 32'h0);
    run(PG_CYC, FSQ_OP_PAGE_ERASE, {a[15:9], 9'h0}, d);
    rd(FSQ_OFF_STAT, 32'h10, 32'h10);
    wr(FSQ_OFF_STAT, 32'h10);
    wr(FSQ_OFF_ARRAY, 32'h0);
    wr(FSQ_OFF_STAT, 32'h0);
    rd(FSQ_OFF_STAT, 32'h10, 32'h10);
    cmd(a, d, FSQ_CMD_BLANK);
    repeat (3) @(negedge i_clk);
    check("array idle", 32'h0, {31'h0, active});
    wr(FSQ_OFF_STAT, 32'h10);
    wr(FSQ_OFF_ARRAY, 32'h0);
    wr(FSQ_OFF_CMD, 32'h33);
    rd(FSQ_OFF_STAT, 32'h10, 32'h10);
    do_reset(8'h00);
    wr(FSQ_OFF_DIV, 32'h5F);
    key_entry(key, 1'b1);
    cmd(a, d, FSQ_CMD_MASS_ERASE);
    run(MS_CYC, FSQ_OP_MASS_ERASE, a, d);
    cmd(a, d, FSQ_CMD_BLANK);
    run(0, FSQ_OP_BLANK, a, d);
    repeat (2) @(negedge i_clk);
    check("secure", 32'h0, {31'h0, secure});
    for (int i = 0; i < 4; i++) begin
      do_reset(8'(i));
      check("secure", {31'h0, i != 2}, {31'h0, secure});
    end
    final_report();
  end
endmodule

bind fsq_sequencer fsq_sequencer_sva u_sva (.*);
